// file: src/hwd_defs.svh
// hwd_defs.svh: register offsets, field positions, characters and
// timing for the host watchdog command handler.
// assumes: included by bare name; definitions only.
`ifndef HWD_DEFS_SVH
`define HWD_DEFS_SVH
`define CTRL_OFS      12'h000
`define STAT_OFS      12'h004
`define TIME_OFS      12'h008
`define LINK_OFS      12'h00c
`define CTRL_SUM_BIT  8
`define CTRL_SAFE_BIT 9
`define CTRL_DOUT_BIT 10
`define RST_MOD_ADDR  8'h01
`define ST_TO_BIT     2
`define ST_EN_BIT     7
`define CLK_NS        4
`define MS_NS         1000000
`define TENTH_NS      100000000
`define TENTH_LAST    4'h9
`define MAX_DELAY_MS  8'h1e
`define MAX_WIN_S     8'h3c
`define CH_TILDE      8'h7e
`define CH_PCT        8'h25
`define CH_CR         8'h0d
`define CH_OK         8'h21
`define CH_BAD        8'h3f
`define CH_R          8'h52
`define CH_D          8'h44
`define CH_T          8'h54
`define CH_I          8'h49
`define CH_0          8'h30
`define CH_1          8'h31
`define CH_2          8'h32
`define CH_3          8'h33
`endif

// file: src/hwd_pkg.sv
// hwd_pkg: state types of the command handler.
// assumes: compiled before every file that names it.
package hwd_pkg;
    typedef enum logic [3:0] {
        P_IDLE = 4'b0001,
        P_EXEC = 4'b0010,
        P_WAIT = 4'b0100,
        P_SEND = 4'b1000
    } parse_st_t;
    typedef enum logic [1:0] {
        T_IDLE = 2'b01,
        T_RUN  = 2'b10
    } tx_st_t;
endpackage

// file: src/reply_if.sv
// reply_if: reply request from the parser to the reply sender.
// assumes: both ends on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface reply_if;
    logic        req;
    logic        ok;
    logic [7:0]  addr;
    logic [1:0]  ndig;
    logic [11:0] data;
    logic        sum_en;
    logic        busy;
    modport src (output req, ok, addr, ndig, data, sum_en,
                 input busy);
    modport snk (input req, ok, addr, ndig, data, sum_en,
                 output busy);
endinterface
`default_nettype wire

// file: src/reply_tx.sv
// reply_tx: turns a reply request into lead, address, data digits,
// optional sum and carriage return.
// assumes: the byte sink holds tx_ready low to stall.
`timescale 1ns/1ps
`default_nettype none
`include "hwd_defs.svh"
module reply_tx (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // request from the parser
    reply_if.snk            rep,
    // byte stream out
    output var  logic       tx_valid,
    output var  logic [7:0] tx_data,
    input  wire logic       tx_ready
);
    hwd_pkg::tx_st_t st_reg;
    logic        ok_reg, sen_reg, vld_reg;
    logic [1:0]  nd_reg;
    logic [11:0] data_reg;
    logic [7:0]  addr_reg, sum_reg, dat_reg;
    logic [3:0]  idx_reg;

    function automatic logic [7:0] hexc(input logic [3:0] n);
        return (n < 4'ha) ? {4'h3, n} : 8'h37 + {4'h0, n};
    endfunction

    wire [3:0] nd4    = {2'b00, nd_reg};
    wire       in_dig = idx_reg >= 4'd3 && idx_reg < 4'd3 + nd4;
    wire       s_hi   = sen_reg && idx_reg == 4'd3 + nd4;
    wire       s_lo   = sen_reg && idx_reg == 4'd4 + nd4;
    wire [1:0] nsel   = 2'(nd4 - 4'd1 - (idx_reg - 4'd3));
    wire [11:0] nsh   = data_reg >> {nsel, 2'b00};
    wire [7:0] cur    =
        idx_reg == 4'd0 ? (ok_reg ? `CH_OK : `CH_BAD) :
        idx_reg == 4'd1 ? hexc(addr_reg[7:4]) :
        idx_reg == 4'd2 ? hexc(addr_reg[3:0]) :
        in_dig ? hexc(nsh[3:0]) :
        s_hi ? hexc(sum_reg[7:4]) :
        s_lo ? hexc(sum_reg[3:0]) : `CH_CR;
    wire load  = st_reg == hwd_pkg::T_RUN && (!vld_reg || tx_ready);
    wire start = rep.req && st_reg == hwd_pkg::T_IDLE && !vld_reg;

    assign rep.busy = st_reg == hwd_pkg::T_RUN || vld_reg;
    assign tx_valid = vld_reg;
    assign tx_data  = dat_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg   <= hwd_pkg::T_IDLE;
            {ok_reg, sen_reg, nd_reg} <= 4'h0;
            data_reg <= 12'h000;
            addr_reg <= 8'h00;
            idx_reg  <= 4'h0;
            sum_reg  <= 8'h00;
        end else if (start) begin
            st_reg   <= hwd_pkg::T_RUN;
            {ok_reg, sen_reg, nd_reg} <= {rep.ok, rep.sum_en, rep.ndig};
            data_reg <= rep.data;
            addr_reg <= rep.addr;
            idx_reg  <= 4'h0;
            sum_reg  <= 8'h00;
        end else if (load) begin
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg < 4'd3 + nd4) sum_reg <= sum_reg + cur;
            if (cur == `CH_CR) st_reg <= hwd_pkg::T_IDLE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vld_reg <= 1'b0;
            dat_reg <= 8'h00;
        end else if (load) begin
            vld_reg <= 1'b1;
            dat_reg <= cur;
        end else if (tx_ready) begin
            vld_reg <= 1'b0;
        end
    end

    lead_char_a: assert property (@(posedge clk) disable iff (!reset_n)
        load && idx_reg == 4'd0 |=>
        tx_valid && tx_data == (ok_reg ? `CH_OK : `CH_BAD))
        else $error("reply lead character wrong");
endmodule
`default_nettype wire

// file: src/host_watchdog_command_handler.sv
// host_watchdog_command_handler: parses tilde and percent frames,
// keeps reply delay, init window and host watchdog, answers frames.
// assumes: rx bytes come from a receiver on clk; APB on clk.
//
// Design decisions made here: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "hwd_defs.svh"
module host_watchdog_command_handler #(
    parameter int MS_CYC    = `MS_NS / `CLK_NS,
    parameter int TENTH_CYC = `TENTH_NS / `CLK_NS,
    parameter int BUF_LEN   = 12
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // command bytes in
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_err,
    // reply bytes out
    output var  logic        tx_valid,
    output var  logic [7:0]  tx_data,
    input  wire logic        tx_ready,
    // output pin and flag storage
    output var  logic        dout,
    output var  logic        wdog_to_nv,
    input  wire logic        wdog_to_nv_in
);
    localparam int CW = $clog2(BUF_LEN + 1);
    localparam int MW = $clog2(MS_CYC);
    localparam int TW = $clog2(TENTH_CYC);

    hwd_pkg::parse_st_t state_reg, state_next;
    reply_if rep ();

    logic [7:0]    buf_mem [BUF_LEN];
    logic [CW-1:0] cnt_reg;
    logic          col_reg, bad_reg;
    logic [7:0]    my_addr_reg, delay_reg, win_s_reg, init_left_reg;
    logic          sum_en_reg, safe_reg, dout_reg;
    logic          wd_en_reg, to_reg, init_act_reg, win_set_reg;
    logic [7:0]    wd_val_reg, wd_cnt_reg, baud_reg, fmt_reg;
    logic [7:0]    ms_left_reg;
    logic [MW-1:0] ms_cyc_reg;
    logic [TW-1:0] tp_cnt_reg;
    logic [3:0]    sec_sub_reg;
    logic          rep_ok_reg;
    logic [1:0]    rep_nd_reg, boot_reg;
    logic [11:0]   rep_data_reg;
    logic          nv_s1_reg, nv_s2_reg;
    logic [31:0]   prdata_reg;

    function automatic logic [4:0] hexv(input logic [7:0] c);
        logic [7:0] l;
        l = c | 8'h20;
        if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
        if (l >= 8'h61 && l <= 8'h66) return {1'b1, c[3:0] + 4'h9};
        return 5'h00;
    endfunction

    // apb slave: zero wait states, error on unmapped word
    wire hit_ctrl = paddr == `CTRL_OFS;
    wire hit_stat = paddr == `STAT_OFS;
    wire hit_time = paddr == `TIME_OFS;
    wire hit_link = paddr == `LINK_OFS;
    wire mapped   = hit_ctrl | hit_stat | hit_time | hit_link;
    wire apb_wr   = psel & penable & pwrite & hit_ctrl;
    wire [31:0] ctrl_rd = {21'h0, dout_reg, safe_reg, sum_en_reg,
                           my_addr_reg};
    wire [31:0] stat_rd = {16'h0, wd_val_reg, 4'h0, win_set_reg,
                           init_act_reg, to_reg, wd_en_reg};
    wire [31:0] rd_mux  = hit_ctrl ? ctrl_rd : hit_stat ? stat_rd :
                          hit_time ? {16'h0, win_s_reg, delay_reg} :
                          hit_link ? {16'h0, fmt_reg, baud_reg} : 32'h0;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_reg;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) prdata_reg <= 32'h0;
        else if (psel && !penable && !pwrite) prdata_reg <= rd_mux;
    end

    // frame collection
    wire rx_take  = rx_valid && state_reg == hwd_pkg::P_IDLE;
    wire rx_lead  = rx_data == `CH_TILDE || rx_data == `CH_PCT;
    wire is_cr    = rx_data == `CH_CR;
    wire buf_full = cnt_reg == CW'(BUF_LEN);
    wire rx_end   = rx_take && !rx_lead && col_reg && is_cr;
    wire buf_we   = rx_take && (rx_lead || (col_reg && !is_cr &&
                    !buf_full));
    wire [CW-1:0] wr_idx = rx_lead ? CW'(0) : cnt_reg;

    always_ff @(posedge clk) begin
        if (buf_we) buf_mem[wr_idx] <= rx_data;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
            col_reg <= 1'b0;
            bad_reg <= 1'b0;
        end else if (rx_take && rx_lead) begin
            cnt_reg <= CW'(1);
            col_reg <= 1'b1;
            bad_reg <= rx_err;
        end else if (rx_take && col_reg) begin
            bad_reg <= bad_reg | rx_err | (buf_full & ~is_cr);
            if (is_cr) col_reg <= 1'b0;
            else if (!buf_full) cnt_reg <= cnt_reg + CW'(1);
        end
    end

    // frame decode
    logic [BUF_LEN-1:0] hv;
    logic [3:0]         hn [BUF_LEN];
    for (genvar g = 0; g < BUF_LEN; g++) begin : g_hex
        assign {hv[g], hn[g]} = hexv(buf_mem[g]);
    end

    wire [CW-1:0] bl = sum_en_reg ? cnt_reg - CW'(2) : cnt_reg;
    logic [7:0] calc_sum;
    always_comb begin
        calc_sum = 8'h00;
        for (int i = 0; i < BUF_LEN; i++) begin
            if (CW'(i) < bl) calc_sum = calc_sum + buf_mem[i];
        end
    end
    wire sum_ok = !sum_en_reg || (cnt_reg >= CW'(5) && hv[bl] &&
                  hv[bl + CW'(1)] &&
                  {hn[bl], hn[bl + CW'(1)]} == calc_sum);
    wire [7:0] c3 = buf_mem[3];
    wire [7:0] b4 = buf_mem[4];
    wire tld   = buf_mem[0] == `CH_TILDE;
    wire addr_ok = hv[1] & hv[2] &
                   ({hn[1], hn[2]} == my_addr_reg);
    wire frame_ok = !bad_reg && sum_ok && bl >= CW'(4) && addr_ok;
    wire rd_cmd = tld && c3 == `CH_R && b4 == `CH_D;
    wire m_rd_rd  = rd_cmd && bl == CW'(5);
    wire m_rd_set = rd_cmd && bl == CW'(7) && hv[5] && hv[6];
    wire m_win  = tld && bl == CW'(6) && c3 == `CH_T && hv[4] && hv[5];
    wire m_init = tld && bl == CW'(4) && c3 == `CH_I;
    wire m_st   = tld && bl == CW'(4) && c3 == `CH_0;
    wire m_clr  = tld && bl == CW'(4) && c3 == `CH_1;
    wire m_to   = tld && bl == CW'(4) && c3 == `CH_2;
    wire m_cfg  = tld && bl == CW'(7) && c3 == `CH_3 &&
                  (b4 == `CH_0 || b4 == `CH_1) && hv[5] && hv[6];
    wire m_link = buf_mem[0] == `CH_PCT && bl == CW'(11) &&
                  &hv[10:3];
    wire known  = m_rd_rd | m_rd_set | m_win | m_init | m_st | m_clr |
                  m_to | m_cfg | m_link;
    wire exec   = state_reg == hwd_pkg::P_EXEC;
    wire take   = exec && frame_ok && known;
    wire [7:0] val56 = {hn[5], hn[6]};
    wire [7:0] val45 = {hn[4], hn[5]};
    wire ok_w = m_rd_set ? val56 <= `MAX_DELAY_MS :
                m_win ? val45 <= `MAX_WIN_S :
                m_link ? init_act_reg & win_set_reg :
                1'b1;
    wire acc  = take && ok_w;
    // a cleared status with the watchdog off reads as 00
    wire [7:0] st_byte = (8'(wd_en_reg) << `ST_EN_BIT) |
                         (8'(to_reg) << `ST_TO_BIT);
    wire [1:0] nd_w = (m_rd_rd | m_st) ? 2'd2 : m_to ? 2'd3 : 2'd0;
    wire [11:0] data_w =
        m_rd_rd ? {4'h0, delay_reg} :
        m_st ? {4'h0, st_byte} :
        {3'h0, wd_en_reg, wd_val_reg};

    // time base: tenths of a second and seconds
    wire tenth_tick = tp_cnt_reg == TW'(TENTH_CYC - 1);
    wire sec_tick   = tenth_tick && sec_sub_reg == `TENTH_LAST;
    wire wd_fire    = wd_en_reg && !take && tenth_tick &&
                      wd_cnt_reg + 8'h01 == wd_val_reg;
    wire boot_load  = boot_reg == 2'd2;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            tp_cnt_reg  <= '0;
            sec_sub_reg <= 4'h0;
        end else if (tenth_tick) begin
            tp_cnt_reg  <= '0;
            sec_sub_reg <= sec_tick ? 4'h0 : sec_sub_reg + 4'h1;
        end else begin
            tp_cnt_reg <= tp_cnt_reg + TW'(1);
        end
    end

    // host watchdog; the flag is restored from storage after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            nv_s1_reg <= 1'b0;
            nv_s2_reg <= 1'b0;
            boot_reg  <= 2'd0;
        end else begin
            nv_s1_reg <= wdog_to_nv_in;
            nv_s2_reg <= nv_s1_reg;
            if (boot_reg != 2'd3) boot_reg <= boot_reg + 2'd1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) to_reg <= 1'b0;
        else if (boot_load) to_reg <= nv_s2_reg | wd_fire;
        else if (wd_fire) to_reg <= 1'b1;   // set beats clear
        else if (acc && m_clr) to_reg <= 1'b0;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wd_en_reg  <= 1'b0;
            wd_val_reg <= 8'h00;
            wd_cnt_reg <= 8'h00;
        end else begin
            if (take || !wd_en_reg) wd_cnt_reg <= 8'h00;
            else if (tenth_tick) wd_cnt_reg <= wd_cnt_reg + 8'h01;
            if (wd_fire) wd_en_reg <= 1'b0;
            else if (acc && m_cfg) begin
                wd_en_reg  <= b4[0];
                wd_val_reg <= val56;
            end
        end
    end

    // software settings; a timeout overrides the output level
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            my_addr_reg <= `RST_MOD_ADDR;
            sum_en_reg  <= 1'b0;
            safe_reg    <= 1'b0;
            dout_reg    <= 1'b0;
        end else begin
            if (apb_wr) begin
                my_addr_reg <= pwdata[7:0];
                sum_en_reg  <= pwdata[`CTRL_SUM_BIT];
                safe_reg    <= pwdata[`CTRL_SAFE_BIT];
            end
            if (wd_fire) dout_reg <= safe_reg;
            else if (apb_wr) dout_reg <= pwdata[`CTRL_DOUT_BIT];
        end
    end
    assign dout       = dout_reg;
    assign wdog_to_nv = to_reg;

    // delay, init window and link settings
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            delay_reg     <= 8'h00;
            win_s_reg     <= 8'h00;
            win_set_reg   <= 1'b0;
            init_act_reg  <= 1'b0;
            init_left_reg <= 8'h00;
            baud_reg      <= 8'h00;
            fmt_reg       <= 8'h00;
        end else begin
            if (acc && m_rd_set) delay_reg <= val56;
            if (acc && m_win) begin
                win_s_reg   <= val45;
                win_set_reg <= 1'b1;
            end
            if (acc && m_init) begin
                init_act_reg  <= 1'b1;
                init_left_reg <= win_s_reg;
            end else if (sec_tick && init_act_reg) begin
                if (init_left_reg == 8'h00) init_act_reg <= 1'b0;
                else init_left_reg <= init_left_reg - 8'h01;
            end
            if (acc && m_link) begin
                baud_reg <= {hn[7], hn[8]};
                fmt_reg  <= {hn[9], hn[10]};
            end
        end
    end

    // reply scheduling
    wire rep_req = state_reg == hwd_pkg::P_WAIT && ms_left_reg == 8'h00
                   && !rep.busy;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            hwd_pkg::P_IDLE: if (rx_end) state_next = hwd_pkg::P_EXEC;
            hwd_pkg::P_EXEC: begin
                state_next = take ? hwd_pkg::P_WAIT : hwd_pkg::P_IDLE;
            end
            hwd_pkg::P_WAIT: if (rep_req) state_next = hwd_pkg::P_SEND;
            hwd_pkg::P_SEND: if (!rep.busy) state_next = hwd_pkg::P_IDLE;
            default: state_next = hwd_pkg::P_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg    <= hwd_pkg::P_IDLE;
            rep_ok_reg   <= 1'b0;
            rep_nd_reg   <= 2'd0;
            rep_data_reg <= 12'h000;
        end else begin
            state_reg <= state_next;
            if (exec) begin
                rep_ok_reg   <= ok_w;
                rep_nd_reg   <= ok_w ? nd_w : 2'd0;
                rep_data_reg <= data_w;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ms_left_reg <= 8'h00;
            ms_cyc_reg  <= '0;
        end else if (exec) begin
            ms_left_reg <= delay_reg;
            ms_cyc_reg  <= '0;
        end else if (state_reg == hwd_pkg::P_WAIT &&
                     ms_left_reg != 8'h00) begin
            if (ms_cyc_reg == MW'(MS_CYC - 1)) begin
                ms_cyc_reg  <= '0;
                ms_left_reg <= ms_left_reg - 8'h01;
            end else begin
                ms_cyc_reg <= ms_cyc_reg + MW'(1);
            end
        end
    end

    assign rep.req    = rep_req;
    assign rep.ok     = rep_ok_reg;
    assign rep.addr   = my_addr_reg;
    assign rep.ndig   = rep_nd_reg;
    assign rep.data   = rep_data_reg;
    assign rep.sum_en = sum_en_reg;

    reply_tx u_tx (
        .clk      (clk),
        .reset_n  (reset_n),
        .rep      (rep.snk),
        .tx_valid (tx_valid),
        .tx_data  (tx_data),
        .tx_ready (tx_ready)
    );

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_quiet;
        state_reg == hwd_pkg::P_IDLE && !rep.req;
    endsequence
    sequence s_clr;
        acc && m_clr && !wd_fire;
    endsequence

    delay_store_a: assert property (acc && m_rd_set |=>
        delay_reg == $past(val56))
        else $error("accepted delay not stored");
    delay_keep_a: assert property (take && m_rd_set &&
        val56 > `MAX_DELAY_MS |=> delay_reg == $past(delay_reg) &&
        !rep_ok_reg) else $error("out of range delay changed");
    silent_drop_a: assert property (exec && !take |=>
        s_quiet) else $error("dropped frame not silent");
    link_gate_a: assert property (take && m_link &&
        !win_set_reg |=> !rep_ok_reg && $stable(baud_reg))
        else $error("link change not refused");
    status_bit_a: assert property (take && m_st |=>
        rep_data_reg[`ST_TO_BIT] == $past(to_reg))
        else $error("status bit 2 wrong");
    clear_flag_a: assert property (s_clr |=> !to_reg)
        else $error("timeout flag not cleared");
    fire_disable_a: assert property (wd_fire |=>
        to_reg && !wd_en_reg) else $error("timeout did not disable");
    safe_out_a: assert property (wd_fire |=>
        dout == $past(safe_reg)) else $error("output not safe value");
    zero_delay_a: assert property (take && delay_reg == 8'h00
        |=> rep.req) else $error("zero delay reply late");
endmodule
`default_nettype wire

// file: dv/host_link_model.sv
// host_link_model: host side of the serial link, sends frames, takes replies.
// assumes: same clock as the handler; replies end with a carriage return.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
    // clock
    input  wire logic       clk,
    // command bytes to the handler
    output var  logic       rx_valid,
    output var  logic [7:0] rx_data,
    output var  logic       rx_err,
    // reply bytes from the handler
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output var  logic       tx_ready
);
    string      got  = "";
    int         nrep = 0;
    logic [1:0] slow = 2'h0;
    // stalls every other pair of cycles so held bytes are exercised
    assign tx_ready = slow[1];
    initial begin
        rx_valid = 1'b0;
        rx_data  = 8'h00;
        rx_err   = 1'b0;
    end
    always @(posedge clk) begin
        slow <= slow + 2'h1;
        if (tx_valid === 1'b1 && tx_ready) begin
            if (tx_data === 8'h0d) nrep <= nrep + 1;
            else got <= {got, string'(tx_data)};
        end
    end
    // frame opens with the lead the caller gives, closes with CR
    task automatic send(input string s, input logic bad);
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_data  <= (i == s.len()) ? 8'h0d : s[i];
            rx_err   <= bad;
            @(posedge clk);
            rx_valid <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// file: dv/tb_host_watchdog_command_handler.sv
// tb_host_watchdog_command_handler: frame and APB sequences with replies.
// assumes: checksums off until the last scenario; short ms and tenth
// counts set below.
`timescale 1ns/1ps
`default_nettype none
module tb_host_watchdog_command_handler;
    logic        clk = 1'b0, reset_n = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, rx_valid, rx_err, tx_valid, tx_ready;
    logic [7:0]  rx_data, tx_data;
    logic        dout, wdog_to_nv;
    int          fail_count = 0, num_checks = 0, cyc = 0;
    logic [2:0]  up_cnt = 3'h0;
    logic        nv_keep = 1'b0;
    // flag store keeps its bit through reset and follows the flag only
    // once the handler has had time to reload it
    always @(posedge clk) begin
        if (!reset_n) up_cnt <= 3'h0;
        else if (up_cnt != 3'h4) up_cnt <= up_cnt + 3'h1;
        if (reset_n && up_cnt == 3'h4) nv_keep <= wdog_to_nv;
    end
    always #2 clk = ~clk;
    host_watchdog_command_handler #(.MS_CYC(20), .TENTH_CYC(50)) u_dut (
        .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_err(rx_err), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .dout(dout),
        .wdog_to_nv(wdog_to_nv), .wdog_to_nv_in(nv_keep));
    host_link_model u_host (.clk(clk), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_err(rx_err), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // an empty expected string means the handler must stay silent
    task automatic cmd(input string c, input string r, input logic bad);
        int    n0, k, l0;
        string s;
        n0 = u_host.nrep;
        l0 = u_host.got.len();
        u_host.send(c, bad);
        k = 0;
        while (u_host.nrep == n0 && k < (r == "" ? 1000 : 5000)) begin
            @(posedge clk);
            k++;
        end
        s = u_host.got.substr(l0, u_host.got.len() - 1);
        num_checks++;
        if ((r == "") ? (u_host.nrep != n0) : (s != r)) begin
            fail_count++;
            $display("CHECK FAILED %0t sent %s got %s", $time, c, s);
        end
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00000001);
        apb(1'b0, 12'h010, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 12'h000, 32'h00000201);
        cmd("~01RD", "!0100", 1'b0);
        cmd("~02RD", "", 1'b0);
        cmd("~01RD", "", 1'b1);
        cmd("~01RD1F", "?01", 1'b0);
        cmd("~01RD1E", "!01", 1'b0);
        cmd("~01RD", "!011E", 1'b0);
        cmd("%0107400740", "?01", 1'b0);
        cmd("~01T3D", "?01", 1'b0);
        cmd("~01T10", "!01", 1'b0);
        cmd("~01I", "!01", 1'b0);
        cmd("%0107400740", "!01", 1'b0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0000101e);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, 32'h00004007);
        cmd("~013164", "!01", 1'b0);
        cmd("~012", "!01164", 1'b0);
        cmd("~010", "!0180", 1'b0);
        cmd("~013101", "!01", 1'b0);
        repeat (200) @(posedge clk);
        chk({31'h0, dout}, 32'h1);
        chk({31'h0, wdog_to_nv}, 32'h1);
        cmd("~010", "!0104", 1'b0);
        cmd("~012", "!01001", 1'b0);
        // restart: the flag must come back from the store
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        cmd("~010", "!0104", 1'b0);
        cmd("~011", "!01", 1'b0);
        chk({31'h0, wdog_to_nv}, 32'h0);
        cmd("~010", "!0100", 1'b0);
        apb(1'b1, 12'h000, 32'h00000301);
        cmd("~0100F", "!0100E2", 1'b0);
        cmd("~01000", "", 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
